// File: pkg/ddlm_pkg.sv
// constants and carrier types for the driver diagnostic and load monitor
package ddlm_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 100;
    localparam int RETRY_PAUSE_NS   = 10000;
    localparam int RETRY_PAUSE_CYC  =
        (RETRY_PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAN_TIME_NS    = 1000000;
    localparam int CLEAN_TIME_CYC   = CLEAN_TIME_NS / CLK_PERIOD_NS;
    localparam int SHORT_RETRIES    = 3;

    // ------------------------------------------------------------------
    // temperature levels in degrees celsius
    // ------------------------------------------------------------------
    localparam logic [7:0] TEMP_WARN_C = 8'h78;
    localparam logic [7:0] TEMP_SHDN_C = 8'h96;

    // ------------------------------------------------------------------
    // load measurement
    // ------------------------------------------------------------------
    localparam int          LOAD_W      = 10;
    localparam int          THR_W       = 7;
    localparam int          THR_SHIFT   = 4;
    localparam logic [9:0]  LOAD_MAX    = 10'h3FF;
    localparam int          FILT_STEPS  = 4;
    localparam int          STEP_PER_W  = 20;

    // ------------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_LOWVEL   = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_CLR  = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h14;

    // control register fields
    localparam int CTRL_FILT_BIT = 0;
    localparam int CTRL_THR_LSB  = 8;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [19:0] LOWVEL_RESET = 20'h00000;

    // interrupt event bits
    localparam int IRQ_W        = 8;
    localparam int EV_WARN      = 0;
    localparam int EV_SHDN      = 1;
    localparam int EV_S2G_A     = 2;
    localparam int EV_S2G_B     = 3;
    localparam int EV_OPEN_A    = 4;
    localparam int EV_OPEN_B    = 5;
    localparam int EV_STALL     = 6;
    localparam int EV_LOAD_NEW  = 7;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SHORT_RUN,
        SHORT_PAUSE,
        SHORT_LATCHED
    } ddlm_short_st_t;

    // driver status word, bit 31 down to bit 0
    typedef struct packed {
        logic [8:0]  reserved;
        logic        stall;
        logic        open_load_b;
        logic        open_load_a;
        logic        bridge_b_ground_short_flag;
        logic        bridge_a_ground_short_flag;
        logic        overheat_shutdown_flag;
        logic        overheat_warn_flag;
        logic [5:0]  zero;
        logic [9:0]  load_measure_value;
    } ddlm_status_t;

endpackage

// File: rtl/ddlm_top.sv
// driver diagnostic flags, short protection and load measurement
`timescale 1ns/10ps
`default_nettype none

module ddlm_top #(
    parameter int CLEAN_CYC = ddlm_pkg::CLEAN_TIME_CYC
) (
    // clock and reset
    input  wire logic                 clock_i,
    input  wire logic                 srst_i,
    // apb slave
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [7:0]           paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    // pins from the power stage and sensors
    input  wire logic                 drv_enable_i,
    input  wire logic [7:0]           temp_c_i,
    input  wire logic [1:0]           hs_overcurrent_i,
    input  wire logic [1:0]           coil_current_ok_i,
    // on-chip step and load inputs
    input  wire logic                 fullstep_i,
    input  wire logic [9:0]           load_raw_i,
    input  wire logic [19:0]          measured_step_period_i,
    // outputs
    output logic [1:0]                bridge_enable_o,
    output logic                      stall_o,
    output logic                      irq_o
);

    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    if (CLEAN_CYC < 1 || CLEAN_CYC > 1048575) begin : g_bad_clean
        $error("CLEAN_CYC out of range");
    end
    default clocking dcb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // temperature code is assumed slow; a torn sample lasts one cycle only
    logic [12:0] pin_s1_q;
    logic [12:0] pin_s2_q;
    always_ff @(posedge clock_i) begin
        pin_s1_q <= {drv_enable_i, temp_c_i, hs_overcurrent_i,
                     coil_current_ok_i};
        pin_s2_q <= pin_s1_q;
    end
    wire logic       drv_en_s  = pin_s2_q[12];
    wire logic [7:0] temp_s    = pin_s2_q[11:4];
    wire logic [1:0] oc_s      = pin_s2_q[3:2];
    wire logic [1:0] coil_ok_s = pin_s2_q[1:0];

    // ------------------------------------------------------------------
    // temperature protection
    // ------------------------------------------------------------------
    logic warn_q;
    logic ot_q;
    wire logic at_warn = temp_s >= ddlm_pkg::TEMP_WARN_C;
    wire logic at_shdn = temp_s >= ddlm_pkg::TEMP_SHDN_C;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            warn_q <= 1'b0;
            ot_q   <= 1'b0;
        end else begin
            warn_q <= at_warn;
            // hysteresis: release only below the warning level
            if (at_shdn) begin
                ot_q <= 1'b1;
            end else if (!at_warn) begin
                ot_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // short to ground, one handler per bridge
    // ------------------------------------------------------------------
    ddlm_pkg::ddlm_short_st_t sh_st_q [2];
    logic [1:0]  sh_retry_q [2];
    logic [13:0] sh_pause_q [2];
    logic [19:0] sh_clean_q [2];
    logic [1:0]  short_flag;
    logic [1:0]  bridge_on;
    for (genvar b = 0; b < 2; b++) begin : g_bridge
        assign short_flag[b] = sh_st_q[b] == ddlm_pkg::SHORT_LATCHED;
        assign bridge_on[b]  = drv_en_s && !ot_q
                               && sh_st_q[b] == ddlm_pkg::SHORT_RUN;
        wire logic hit = oc_s[b] && bridge_on[b];
        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                sh_st_q[b]    <= ddlm_pkg::SHORT_RUN;
                sh_retry_q[b] <= 2'h0;
                sh_pause_q[b] <= 14'h0000;
                sh_clean_q[b] <= 20'h00000;
            end else begin
                case (sh_st_q[b])
                    ddlm_pkg::SHORT_RUN: begin
                        if (hit && sh_retry_q[b] == 2'(ddlm_pkg::SHORT_RETRIES)
                        ) begin
                            sh_st_q[b] <= ddlm_pkg::SHORT_LATCHED;
                        end else if (hit) begin
                            sh_retry_q[b] <= sh_retry_q[b] + 2'h1;
                            sh_pause_q[b] <= 14'(ddlm_pkg::RETRY_PAUSE_CYC);
                            sh_st_q[b]    <= ddlm_pkg::SHORT_PAUSE;
                        end else if (sh_clean_q[b] != 20'h00000) begin
                            sh_clean_q[b] <= sh_clean_q[b] - 20'h00001;
                        end else begin
                            // glitch forgotten after a clean stretch
                            sh_retry_q[b] <= 2'h0;
                        end
                    end
                    ddlm_pkg::SHORT_PAUSE: begin
                        sh_clean_q[b] <= 20'(CLEAN_CYC);
                        if (sh_pause_q[b] == 14'h0001) begin
                            sh_st_q[b] <= ddlm_pkg::SHORT_RUN;
                        end
                        sh_pause_q[b] <= sh_pause_q[b] - 14'h0001;
                    end
                    ddlm_pkg::SHORT_LATCHED: begin
                        if (!drv_en_s) begin
                            sh_st_q[b]    <= ddlm_pkg::SHORT_RUN;
                            sh_retry_q[b] <= 2'h0;
                        end
                    end
                    default: sh_st_q[b] <= ddlm_pkg::SHORT_RUN;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // open load, sampled once per full step, report only
    // ------------------------------------------------------------------
    logic [1:0] open_q;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            open_q <= 2'h0;
        end else if (fullstep_i) begin
            open_q <= bridge_on & ~coil_ok_s;
        end
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [19:0] lowvel_q;
    logic [7:0]  irq_stat_q;
    logic [7:0]  irq_en_q;
    wire logic        filt_en = ctrl_q[ddlm_pkg::CTRL_FILT_BIT];
    wire logic [6:0]  thr     =
        ctrl_q[ddlm_pkg::CTRL_THR_LSB +: ddlm_pkg::THR_W];

    // ------------------------------------------------------------------
    // load measurement
    // ------------------------------------------------------------------
    // threshold scaled by 16 shifts the raw reading; result clamped
    wire logic signed [11:0] load_adj =
        $signed({2'b00, load_raw_i}) + $signed({thr[6], thr, 4'h0});
    wire logic [9:0] load_clamp =
        load_adj[11]           ? 10'h000 :
        (load_adj[10] == 1'b1) ? ddlm_pkg::LOAD_MAX :
                                 load_adj[9:0];
    logic [11:0] acc_q;
    logic [1:0]  acc_cnt_q;
    logic [9:0]  load_q;
    logic        load_new_q;
    wire logic [11:0] acc_sum = acc_q + {2'b00, load_clamp};
    wire logic        filt_last = acc_cnt_q == 2'(ddlm_pkg::FILT_STEPS - 1);
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            acc_q      <= 12'h000;
            acc_cnt_q  <= 2'h0;
            load_q     <= 10'h000;
            load_new_q <= 1'b0;
        end else begin
            load_new_q <= 1'b0;
            if (fullstep_i && (!filt_en || filt_last)) begin
                load_q     <= filt_en ? acc_sum[11:2] : load_clamp;
                load_new_q <= 1'b1;
                acc_q      <= 12'h000;
                acc_cnt_q  <= 2'h0;
            end else if (fullstep_i) begin
                acc_q     <= acc_sum;
                acc_cnt_q <= acc_cnt_q + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // stall and bridge outputs
    // ------------------------------------------------------------------
    wire logic vel_ok = lowvel_q >= measured_step_period_i;
    logic stall_q;
    logic [1:0] bridge_q;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            stall_q  <= 1'b0;
            bridge_q <= 2'h0;
        end else begin
            stall_q  <= vel_ok && load_q == 10'h000;
            bridge_q <= bridge_on;
        end
    end
    assign stall_o         = stall_q;
    assign bridge_enable_o = bridge_q;

    // ------------------------------------------------------------------
    // status word and events
    // ------------------------------------------------------------------
    ddlm_pkg::ddlm_status_t status;
    assign status = {9'h000, stall_q, open_q, short_flag, ot_q, warn_q,
                     6'h00, load_q};

    logic [7:0] ev_prev_q;
    wire logic [7:0] ev_level = {1'b0, stall_q, open_q, short_flag,
                                 ot_q, warn_q};
    wire logic [7:0] ev_rise  = (ev_level & ~ev_prev_q)
                                | {load_new_q, 7'h00};

    // ------------------------------------------------------------------
    // apb slave: one wait state, answer on the second access cycle
    // ------------------------------------------------------------------
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        irq_q;
    wire logic access   = psel_i && penable_i && !pready_q;
    wire logic done     = psel_i && penable_i && pready_q;
    wire logic hit_ctrl = paddr_i == ddlm_pkg::ADDR_CTRL;
    wire logic hit_low  = paddr_i == ddlm_pkg::ADDR_LOWVEL;
    wire logic hit_stat = paddr_i == ddlm_pkg::ADDR_STATUS;
    wire logic hit_ist  = paddr_i == ddlm_pkg::ADDR_IRQ_STAT;
    wire logic hit_iclr = paddr_i == ddlm_pkg::ADDR_IRQ_CLR;
    wire logic hit_ien  = paddr_i == ddlm_pkg::ADDR_IRQ_EN;
    wire logic mapped   = hit_ctrl | hit_low | hit_stat | hit_ist
                          | hit_iclr | hit_ien;
    wire logic [31:0] rd_mux =
        hit_ctrl ? ctrl_q :
        hit_low  ? {12'h000, lowvel_q} :
        hit_stat ? status :
        hit_ist  ? {24'h000000, irq_stat_q} :
        hit_ien  ? {24'h000000, irq_en_q} : 32'h0000_0000;
    wire logic wr_ok    = done && pwrite_i;
    wire logic [7:0] clr = (wr_ok && hit_iclr) ? pwdata_i[7:0] : 8'h00;
    wire logic [31:0] ctrl_mask = 32'h0000_7F01;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
            prdata_q   <= 32'h0000_0000;
            ctrl_q     <= ddlm_pkg::CTRL_RESET;
            lowvel_q   <= ddlm_pkg::LOWVEL_RESET;
            irq_stat_q <= 8'h00;
            irq_en_q   <= 8'h00;
            ev_prev_q  <= 8'h00;
            irq_q      <= 1'b0;
        end else begin
            pready_q  <= access;
            pslverr_q <= access && !mapped;
            prdata_q  <= (access && !pwrite_i) ? rd_mux : 32'h0000_0000;
            if (wr_ok && hit_ctrl) begin
                ctrl_q <= pwdata_i & ctrl_mask;
            end
            if (wr_ok && hit_low) begin
                lowvel_q <= pwdata_i[19:0];
            end
            if (wr_ok && hit_ien) begin
                irq_en_q <= pwdata_i[7:0];
            end
            ev_prev_q  <= ev_level;
            // a new event wins over a clear in the same cycle
            irq_stat_q <= (irq_stat_q & ~clr) | ev_rise;
            irq_q      <= |(irq_stat_q & irq_en_q);
        end
    end
    assign prdata_o  = prdata_q;
    assign pready_o  = pready_q;
    assign pslverr_o = pslverr_q;
    assign irq_o     = irq_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_hot; at_shdn ##1 ot_q; endsequence
    sequence s_off_two; !bridge_enable_o[0] && !bridge_enable_o[1]; endsequence
    property p_warn_level;
        at_warn |=> warn_q;
    endproperty
    a_warn_level: assert property (p_warn_level)
        else $error("warning flag not set at warning level");
    property p_shdn_off;
        s_hot |=> s_off_two;
    endproperty
    a_shdn_off: assert property (p_shdn_off)
        else $error("stages not off after overheat");
    property p_ot_hold;
        ot_q && at_warn |=> ot_q;
    endproperty
    a_ot_hold: assert property (p_ot_hold)
        else $error("overheat released above warning level");
    property p_short_retries;
        $rose(short_flag[0]) |-> $past(sh_retry_q[0]) == 2'h3;
    endproperty
    a_short_retries: assert property (p_short_retries)
        else $error("short latched before three retries");
    property p_short_own;
        short_flag[0] && !short_flag[1] && drv_en_s && !ot_q
        |=> !bridge_enable_o[0] && bridge_enable_o[1];
    endproperty
    a_short_own: assert property (p_short_own)
        else $error("short did not isolate bridge a only");
    property p_short_hold;
        short_flag[0] && drv_en_s |=> short_flag[0];
    endproperty
    a_short_hold: assert property (p_short_hold)
        else $error("short flag released while enabled");
    property p_unfilt;
        fullstep_i && !filt_en |=> load_new_q
                                   && load_q == $past(load_clamp);
    endproperty
    a_unfilt: assert property (p_unfilt)
        else $error("unfiltered value not updated on full step");
    property p_filt;
        fullstep_i && filt_en && !filt_last |=> !load_new_q;
    endproperty
    a_filt: assert property (p_filt)
        else $error("filtered value updated before fourth step");
    property p_stall_vel;
        stall_o |-> $past(vel_ok) && $past(load_q) == 10'h000;
    endproperty
    a_stall_vel: assert property (p_stall_vel)
        else $error("stall output outside velocity window");
    property p_open_report;
        fullstep_i && bridge_on[0] && !coil_ok_s[0] |=> open_q[0];
    endproperty
    a_open_report: assert property (p_open_report)
        else $error("open load a not flagged");

endmodule

`default_nettype wire

// File: sim/ddlm_host_model.sv
// host-side model: full steps with load readings and the driver enable
`timescale 1ns/10ps
`default_nettype none
module ddlm_host_model (
    // clock
    input  wire logic       clock_i,
    // towards the monitor
    output logic            fullstep_o,
    output logic [9:0]      load_raw_o,
    output logic            drv_enable_o
);
    initial begin
        fullstep_o   = 1'b0;
        load_raw_o   = 10'h000;
        drv_enable_o = 1'b1;
    end
    // one-cycle full step; raw then flips so a stale sample shows up
    task automatic step(input logic [9:0] raw);
        @(posedge clock_i);
        fullstep_o <= 1'b1;
        load_raw_o <= raw;
        @(posedge clock_i);
        fullstep_o <= 1'b0;
        load_raw_o <= ~raw;
    endtask
    // disable, then enable again, to restart a shorted bridge
    task automatic rearm();
        @(posedge clock_i);
        drv_enable_o <= 1'b0;
        repeat (6) @(posedge clock_i);
        drv_enable_o <= 1'b1;
    endtask
endmodule
`default_nettype wire

// File: sim/ddlm_top_tb_top.sv
// self-checking bench for the diagnostic and load monitor
`timescale 1ns/10ps
`default_nettype none
module ddlm_top_tb_top;
    localparam logic [7:0] ST = ddlm_pkg::ADDR_STATUS;
    localparam logic [7:0] CT = ddlm_pkg::ADDR_CTRL;
    localparam logic [7:0] LV = ddlm_pkg::ADDR_LOWVEL;
    logic        clock_i;
    logic        srst_i;
    logic        psel;
    logic        pen;
    logic        pwr;
    logic [7:0]  paddr;
    logic [31:0] pwd;
    logic [7:0]  temp;
    logic [1:0]  oc;
    logic [1:0]  cok;
    logic [19:0] per;
    logic [31:0] prd;
    logic [9:0]  raw;
    logic [1:0]  br;
    logic        prdy, perr, stall, irq, fs, en;
    int          err_total   = 0;
    int          check_count = 0;
    always #50 clock_i = ~clock_i;
    ddlm_host_model h (.clock_i(clock_i), .fullstep_o(fs),
        .load_raw_o(raw), .drv_enable_o(en));
    // short clean time keeps the retry window brief
    ddlm_top #(.CLEAN_CYC(20)) dut (.clock_i(clock_i), .srst_i(srst_i),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
        .drv_enable_i(en), .temp_c_i(temp), .hs_overcurrent_i(oc),
        .coil_current_ok_i(cok), .fullstep_i(fs), .load_raw_i(raw),
        .measured_step_period_i(per), .bridge_enable_o(br),
        .stall_o(stall), .irq_o(irq));
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; an idle cycle follows so psel is never set twice
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [32:0] r);
        int n;
        n = 0;
        psel  <= 1'b1;
        pwr   <= w;
        paddr <= a;
        pwd   <= d;
        @(posedge clock_i);
        pen <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (prdy !== 1'b1 && n < 50);
        r = {perr, prd};
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clock_i);
        if (n >= 50) begin
            err_total++;
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        logic [32:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r[31:0] & m, e);
    endtask
    task automatic wt(input logic [1:0] e);
        for (int n = 0; n < 400 && br !== e; n++)
            @(posedge clock_i);
        chk({30'h0, br}, {30'h0, e});
        if (br !== e) begin
            summarize();
        end
    endtask
    task automatic t_regs();
        logic [32:0] r;
        rd(CT, 32'hFFFF_FFFF, 32'h0);
        rd(LV, 32'hFFFF_FFFF, 32'h0);
        apb(1'b0, 8'h18, 32'h0, r);
        chk({31'h0, r[32]}, 32'h1);
        wr(ST, 32'hFFFF_FFFF);
        rd(ST, 32'h007F_0000, 32'h0);
    endtask
    task automatic t_temp();
        temp <= 8'h79;
        repeat (8) @(posedge clock_i);
        rd(ST, 32'h0003_0000, 32'h0001_0000);
        chk({30'h0, br}, 32'h3);
        temp <= 8'h97;
        wt(2'h0);
        rd(ST, 32'h0002_0000, 32'h0002_0000);
        temp <= 8'h7D;
        repeat (20) @(posedge clock_i);
        chk({30'h0, br}, 32'h0);
        temp <= 8'h64;
        wt(2'h3);
    endtask
    task automatic t_short();
        oc <= 2'h1;
        repeat (60) @(posedge clock_i);
        rd(ST, 32'h000C_0000, 32'h0);
        repeat (500) @(posedge clock_i);
        chk({30'h0, br}, 32'h2);
        rd(ST, 32'h000C_0000, 32'h0004_0000);
        oc <= 2'h0;
        repeat (200) @(posedge clock_i);
        chk({30'h0, br}, 32'h2);
        h.rearm();
        wt(2'h3);
    endtask
    task automatic t_load();
        wr(ddlm_pkg::ADDR_IRQ_EN, 32'h80);
        h.step(10'h155);
        rd(ST, 32'h3FF, 32'h155);
        chk({31'h0, irq}, 32'h1);
        wr(ddlm_pkg::ADDR_IRQ_CLR, 32'h80);
        wr(ddlm_pkg::ADDR_IRQ_EN, 32'h0);
        wr(CT, 32'h3F00);
        h.step(10'h100);
        rd(ST, 32'h3FF, 32'h3FF);
        chk({31'h0, irq}, 32'h0);
        wr(CT, 32'h4000);
        h.step(10'h100);
        rd(ST, 32'h3FF, 32'h0);
        wr(CT, 32'h7F00);
        h.step(10'h020);
        rd(ST, 32'h3FF, 32'h010);
        wr(CT, 32'h1);
        h.step(10'h010);
        h.step(10'h020);
        h.step(10'h030);
        rd(ST, 32'h3FF, 32'h010);
        h.step(10'h040);
        rd(ST, 32'h3FF, 32'h028);
    endtask
    task automatic t_stall();
        wr(CT, 32'h0);
        wr(LV, 32'h100);
        h.step(10'h0);
        repeat (3) @(posedge clock_i);
        chk({31'h0, stall}, 32'h1);
        per <= 20'h00200;
        h.step(10'h0);
        repeat (3) @(posedge clock_i);
        chk({31'h0, stall}, 32'h0);
        cok <= 2'h2;
        repeat (4) @(posedge clock_i);
        h.step(10'h200);
        rd(ST, 32'h0030_0000, 32'h0010_0000);
        chk({30'h0, br}, 32'h3);
    endtask
    initial begin
        // start values at time zero, before the first clock edge
        clock_i = 1'b0;
        srst_i  = 1'b1;
        psel    = 1'b0;
        pen     = 1'b0;
        pwr     = 1'b0;
        paddr   = 8'h00;
        pwd     = 32'h0000_0000;
        temp    = 8'h19;
        oc      = 2'h0;
        cok     = 2'h3;
        per     = 20'h00080;
        repeat (6) @(posedge clock_i);
        srst_i <= 1'b0;
        wt(2'h3);
        t_regs();
        t_temp();
        t_short();
        t_load();
        t_stall();
        summarize();
    end
endmodule
`default_nettype wire
